// ### rtl/ftsl_defs.vh
// ftsl_defs.vh: register offsets, field positions, reset values and timing counts
// for the fan tach status and limit block; included by the top-level design file only.
`ifndef FTSL_DEFS_VH
`define FTSL_DEFS_VH

// register byte offsets
`define FTSL_OFF_CTRL 8'h00
`define FTSL_OFF_STAT 8'h04
`define FTSL_OFF_UPPER 8'h08
`define FTSL_OFF_LOWER 8'h0C
`define FTSL_OFF_IRQ_MASK 8'h10

// control register fields
`define FTSL_CTRL_RANGE_IE 0
`define FTSL_CTRL_ENABLE 1
`define FTSL_CTRL_EDGE_SEL_LO 11
`define FTSL_CTRL_EDGE_SEL_HI 12
`define FTSL_CTRL_EDGE_IE 14
`define FTSL_CTRL_READY_IE 15
`define FTSL_CTRL_SRC_SEL 10
`define FTSL_CTRL_COUNT_LO 16
`define FTSL_CTRL_COUNT_HI 31

// status register fields
`define FTSL_ST_RANGE 0
`define FTSL_ST_PIN 1
`define FTSL_ST_EDGE 2
`define FTSL_ST_READY 3

// reset values
`define FTSL_RST_UPPER 16'hFFFF
`define FTSL_RST_LOWER 16'h0000
`define FTSL_RST_MASK 4'hF

// slow reference clock: 100 kHz from a 125 MHz clock
`define FTSL_PCLK_HZ 125000000
`define FTSL_REF_HZ 100000
`define FTSL_REF_DIV (`FTSL_PCLK_HZ / `FTSL_REF_HZ)
// divider reload, FTSL_REF_DIV - 1, sized to the 11-bit divider register
`define FTSL_REF_RELOAD 11'h4E1

`endif

// ### rtl/ftsl_sync.v
// ftsl_sync.v: two-flop synchroniser for one asynchronous level.
// assumes the input comes from a pin outside the pclk domain.
`timescale 1ns/1ps

module ftsl_sync (
	input wire pclk,
	input wire presetn,
	input wire async_in,
	output wire sync_out
);
	reg meta_q;
	reg sync_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // ftsl_sync

// ### rtl/ftsl_top.v
// ftsl_top.v: fan tach status flags, speed counter and limit compare, APB slave.
// assumes an APB master on pclk and a raw tach pin asynchronous to pclk.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "ftsl_defs.vh"

// Functional notes
// - reading-ready stays zero while counting tach edges directly.
// - in reference-clock mode, reading-ready sets on each count latch.
// - interrupt asserts while reading-ready set and its enable is one.
// - input-edge flag sets on every rising or falling tach transition while enabled.
// - interrupt asserts while edge flag set and edge enable is one.
// - live tach level readable as status bit; writes ignored.
// - range fault sets when count above upper or below lower bound.
// - interrupt asserts while range fault set and its enable is one.
// - the three flags clear on write-one, keep on zero, reset zero.
// - 16-bit upper bound, resets all ones, fault when count strictly greater.
// - 16-bit lower bound, resets zero, fault when count strictly less.
// - source one counts reference ticks per edge window; zero counts rising edges.
module ftsl_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire tach_pin,
	output wire tach_irq
);
	wire tach_s;
	reg tach_prev_q;
	reg ctrl_range_ie_q;
	reg ctrl_enable_q;
	reg ctrl_src_q;
	reg [1:0] ctrl_edge_sel_q;
	reg ctrl_edge_ie_q;
	reg ctrl_ready_ie_q;
	reg [15:0] upper_q;
	reg [15:0] lower_q;
	reg [3:0] mask_q;
	reg [15:0] speed_count_q;
	reg [15:0] run_count_q;
	reg [3:0] edge_cnt_q;
	reg [3:0] edge_target;
	// 1250 pclk per tick needs eleven bits of divider
	reg [10:0] ref_div_q;
	reg range_q;
	reg edge_q;
	reg ready_q;
	wire wr_en;
	wire rd_en;
	wire pin_edge;
	wire pin_rise;
	wire ref_tick;
	wire latch_now;
	wire range_set;
	wire clr_range;
	wire clr_edge;
	wire clr_ready;
	wire addr_ok;
	wire stat_wr;
	wire irq_range;
	wire irq_edge;
	wire irq_ready;
	reg [31:0] rd_mux;

	// bus timing seen from the master:
	// setup cycle: psel high, penable low, address and direction valid;
	// read data are taken from the mux at this edge.
	// access cycle: penable high, pready already high, so the write lands
	// and the registered read data stand for the master to take.
	// an unmapped address answers with pslverr and changes nothing.

	ftsl_sync u_tach_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tach_pin),
		.sync_out(tach_s)
	);

	// zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign addr_ok = (paddr == `FTSL_OFF_CTRL) || (paddr == `FTSL_OFF_STAT) ||
		(paddr == `FTSL_OFF_UPPER) || (paddr == `FTSL_OFF_LOWER) ||
		(paddr == `FTSL_OFF_IRQ_MASK);
	assign pslverr = psel && penable && !addr_ok;
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign rd_en = psel && penable && !pwrite;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tach_prev_q <= 1'b0;
		end else begin
			tach_prev_q <= tach_s;
		end
	end

	// the block ignores the pin while disabled, so stale edges are not reported
	assign pin_edge = ctrl_enable_q && (tach_s != tach_prev_q);
	assign pin_rise = pin_edge && tach_s;

	// reference tick generator, 100 kHz
	// the divider runs while the block is disabled too, so the first window
	// after enable may start part way into a tick period: one tick of error
	assign ref_tick = (ref_div_q == 11'h000);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_div_q <= 11'h000;
		end else if (ref_tick) begin
			ref_div_q <= `FTSL_REF_RELOAD;
		end else begin
			ref_div_q <= ref_div_q - 11'h001;
		end
	end

	// edge window length, in tach transitions of either polarity:
	// a short window answers fast, a long one averages out an uneven rotor

	always @* begin
		case (ctrl_edge_sel_q)
			2'b00: edge_target = 4'h2;
			2'b01: edge_target = 4'h3;
			2'b10: edge_target = 4'h5;
			default: edge_target = 4'h9;
		endcase
	end

	assign latch_now = ctrl_src_q && pin_edge && (edge_cnt_q + 4'h1 >= edge_target);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_count_q <= 16'h0000;
			speed_count_q <= 16'h0000;
			edge_cnt_q <= 4'h0;
		end else if (!ctrl_enable_q) begin
			edge_cnt_q <= edge_cnt_q;
		end else if (ctrl_src_q) begin
			if (latch_now) begin
				speed_count_q <= run_count_q;
				run_count_q <= 16'h0000;
				edge_cnt_q <= 4'h0;
			end else begin
				if (pin_edge) begin
					edge_cnt_q <= edge_cnt_q + 4'h1;
				end
				// saturate so a fan slower than the counter range latches as the slowest speed
				if (ref_tick && run_count_q != 16'hFFFF) begin
					run_count_q <= run_count_q + 16'h0001;
				end
			end
		end else if (pin_rise) begin
			speed_count_q <= speed_count_q + 16'h0001;
		end
	end

	assign range_set = (speed_count_q > upper_q) || (speed_count_q < lower_q);

	// status writes only clear flags; the pin bit has no storage to write
	assign stat_wr = wr_en && (paddr == `FTSL_OFF_STAT);

	assign clr_range = stat_wr && pwdata[`FTSL_ST_RANGE];
	assign clr_edge = stat_wr && pwdata[`FTSL_ST_EDGE];
	assign clr_ready = stat_wr && pwdata[`FTSL_ST_READY];

	// set wins over a clear in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			range_q <= 1'b0;
			edge_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			if (range_set) begin
				range_q <= 1'b1;
			end else if (clr_range) begin
				range_q <= 1'b0;
			end
			if (pin_edge) begin
				edge_q <= 1'b1;
			end else if (clr_edge) begin
				edge_q <= 1'b0;
			end
			if (!ctrl_src_q) begin
				ready_q <= 1'b0;
			end else if (latch_now) begin
				ready_q <= 1'b1;
			end else if (clr_ready) begin
				ready_q <= 1'b0;
			end
		end
	end

	// register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_range_ie_q <= 1'b0;
			ctrl_enable_q <= 1'b0;
			ctrl_src_q <= 1'b0;
			ctrl_edge_sel_q <= 2'b00;
			ctrl_edge_ie_q <= 1'b0;
			ctrl_ready_ie_q <= 1'b0;
			upper_q <= `FTSL_RST_UPPER;
			lower_q <= `FTSL_RST_LOWER;
			mask_q <= `FTSL_RST_MASK;
		end else if (wr_en) begin
			case (paddr)
				`FTSL_OFF_CTRL: begin
					ctrl_range_ie_q <= pwdata[`FTSL_CTRL_RANGE_IE];
					ctrl_enable_q <= pwdata[`FTSL_CTRL_ENABLE];
					ctrl_src_q <= pwdata[`FTSL_CTRL_SRC_SEL];
					ctrl_edge_sel_q <= pwdata[`FTSL_CTRL_EDGE_SEL_HI:`FTSL_CTRL_EDGE_SEL_LO];
					ctrl_edge_ie_q <= pwdata[`FTSL_CTRL_EDGE_IE];
					ctrl_ready_ie_q <= pwdata[`FTSL_CTRL_READY_IE];
				end
				`FTSL_OFF_UPPER: upper_q <= pwdata[15:0];
				`FTSL_OFF_LOWER: lower_q <= pwdata[15:0];
				`FTSL_OFF_IRQ_MASK: mask_q <= pwdata[3:0];
				default: mask_q <= mask_q;
			endcase
		end
	end

	// read mux; reserved bits read zero
	always @* begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`FTSL_OFF_CTRL: begin
				rd_mux[`FTSL_CTRL_RANGE_IE] = ctrl_range_ie_q;
				rd_mux[`FTSL_CTRL_ENABLE] = ctrl_enable_q;
				rd_mux[`FTSL_CTRL_SRC_SEL] = ctrl_src_q;
				rd_mux[`FTSL_CTRL_EDGE_SEL_HI:`FTSL_CTRL_EDGE_SEL_LO] = ctrl_edge_sel_q;
				rd_mux[`FTSL_CTRL_EDGE_IE] = ctrl_edge_ie_q;
				rd_mux[`FTSL_CTRL_READY_IE] = ctrl_ready_ie_q;
				rd_mux[`FTSL_CTRL_COUNT_HI:`FTSL_CTRL_COUNT_LO] = speed_count_q;
			end
			`FTSL_OFF_STAT: begin
				rd_mux[`FTSL_ST_RANGE] = range_q;
				rd_mux[`FTSL_ST_PIN] = tach_s;
				rd_mux[`FTSL_ST_EDGE] = edge_q;
				rd_mux[`FTSL_ST_READY] = ready_q;
			end
			`FTSL_OFF_UPPER: rd_mux[15:0] = upper_q;
			`FTSL_OFF_LOWER: rd_mux[15:0] = lower_q;
			`FTSL_OFF_IRQ_MASK: rd_mux[3:0] = mask_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data registered during the setup cycle so it is stable in the access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// the mask register sits behind the control enables, so firmware can
	// silence the line without touching the counting configuration

	assign irq_range = range_q &&
		ctrl_range_ie_q &&
		mask_q[`FTSL_ST_RANGE];

	assign irq_edge = edge_q &&
		ctrl_edge_ie_q &&
		mask_q[`FTSL_ST_EDGE];

	assign irq_ready = ready_q &&
		ctrl_ready_ie_q &&
		mask_q[`FTSL_ST_READY];

	// gated OR
	// level output from flops only, so it cannot glitch on bus activity
	assign tach_irq = irq_range ||
		irq_edge ||
		irq_ready;

	// rd_en kept for readability of bus decode; unused reads have no side effect
	wire unused_rd = rd_en;
endmodule // ftsl_top

// ### bench/ftsl_monitor.sv
// ftsl_monitor.sv: port checker for ftsl_top.
// assumes only ftsl_top's ports; shadows ctrl from APB writes.
`timescale 1ns/1ps
module ftsl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tach_pin,
	input wire logic tach_irq
);
	logic [31:0] ctl_q;
	logic up_wr_q;
	logic pin_q;
	logic [2:0] still_q;
	wire wr = psel && penable && pwrite;
	wire rd = psel && penable && !pwrite;
	wire unm = (paddr > 8'h10) || (paddr[1:0] != 2'h0);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 32'h0;
			up_wr_q <= 1'b0;
			pin_q <= 1'b0;
			still_q <= 3'h0;
		end else begin
			if (wr && paddr == 8'h00) ctl_q <= pwdata;
			if (wr && paddr == 8'h08) up_wr_q <= 1'b1;
			pin_q <= tach_pin;
			// pin must settle through the synchroniser before status reflects it
			still_q <= (tach_pin != pin_q) ? 3'h0 : ((still_q == 3'h7) ? 3'h7 : still_q + 3'h1);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_stat_rd;
		rd && paddr == 8'h04;
	endsequence
	sequence s_toggle;
		$changed(tach_pin) && ctl_q[1] && ctl_q[14];
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_err_map: assert property (psel && penable |-> pslverr == unm) else $error("pslverr wrong");
	a_unmapped_zero: assert property (rd && unm |-> prdata == 32'h0) else $error("unmapped read");
	a_irq_cause: assert property (tach_irq |-> ctl_q[0] || ctl_q[14] || ctl_q[15])
		else $error("irq without enable");
	a_edge_irq: assert property (s_toggle |-> ##[1:6] tach_irq)
		else $error("no edge irq");
	a_ready_zero: assert property (s_stat_rd ##0 !ctl_q[10] |-> !prdata[3])
		else $error("ready set in edge mode");
	a_pin_live: assert property (s_stat_rd ##0 still_q == 3'h7 |-> prdata[1] == tach_pin)
		else $error("pin status stale");
	a_upper_rst: assert property (rd && paddr == 8'h08 && !up_wr_q |-> prdata == 32'h0000FFFF)
		else $error("upper reset wrong");
endmodule // ftsl_monitor
bind ftsl_top ftsl_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tach_pin(tach_pin), .tach_irq(tach_irq));

// ### bench/ftsl_fan.sv
// ftsl_fan.sv: fan tach output model, free running or single steps.
// assumes the bench drives run, step and half on pclk edges.
`timescale 1ns/1ps
module ftsl_fan (
	input wire logic pclk,
	input wire logic run,
	input wire logic step,
	input wire logic [15:0] half,
	output logic tach_pin
);
	logic [15:0] cnt_q;
	initial begin
		tach_pin = 1'b0;
		cnt_q = 16'h0000;
	end
	// a stopped fan holds its level, as a locked rotor would
	always @(posedge pclk) begin
		if (step || (run && cnt_q >= half)) begin
			tach_pin <= ~tach_pin;
			cnt_q <= 16'h0000;
		end else if (run) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule // ftsl_fan

// ### bench/testbench.sv
// testbench.sv: self-checking bench for ftsl_top with a fan model.
// assumes zero-wait APB and the 1250-cycle reference tick.
`timescale 1ns/1ps
module testbench;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, step = 0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, seed = 32'hFE90962C, e, m;
	reg [15:0] half = 16'h07D0;
	wire [31:0] prdata;
	wire pready, pslverr, tach_pin, tach_irq;
	integer n_fail = 0, tests_run = 0, cyc = 0, i;
	reg [31:0] eq[$], mq[$];
	ftsl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tach_pin(tach_pin), .tach_irq(tach_irq));
	ftsl_fan fan_u (.pclk(pclk), .run(run), .step(step), .half(half), .tach_pin(tach_pin));
	initial forever #4 pclk = ~pclk;
	task conclude;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, n_fail);
			if (n_fail == 0 && tests_run > 0) $display("bench passed");
			else $display("bench failed");
			$finish;
		end
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail = n_fail + 1;
			conclude;
		end
	end
	// read results are matched against the oldest note
	always @(posedge pclk) if (psel && penable && !pwrite && pready) begin
		e = eq.pop_front();
		m = mq.pop_front();
		tests_run = tests_run + 1;
		if ((prdata & m) !== e) begin
			n_fail = n_fail + 1;
			$display("[ERR] prdata %h exp %h seen %h", paddr, e, prdata & m);
		end
	end
	task xfer(input [7:0] a, input w, input [31:0] d);
		begin
			psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
			@(posedge pclk) penable <= 1;
			@(posedge pclk);
			while (!pready) @(posedge pclk);
			psel <= 0; penable <= 0;
			@(posedge pclk);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d); xfer(a, 1, d); endtask
	task rd(input [7:0] a, input [31:0] x, input [31:0] k);
		begin eq.push_back(x); mq.push_back(k); xfer(a, 0, 32'h0); end
	endtask
	task ck(input x);
		begin
			@(negedge pclk) tests_run = tests_run + 1;
			if (tach_irq !== x) begin
				n_fail = n_fail + 1;
				$display("[ERR] tach_irq exp %b seen %b", x, tach_irq);
			end
			@(posedge pclk);
		end
	endtask
	task spin;
		begin
			run <= 1;
			for (i = 0; i < 20000 && tach_irq !== 1'b1; i = i + 1) @(posedge pclk);
			run <= 0;
		end
	endtask
	task tog; begin step <= 1; @(posedge pclk) step <= 0; repeat (8) @(posedge pclk); end endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(8'h04, 32'h0, 32'hF);
		rd(8'h08, 32'h0000FFFF, 32'hFFFFFFFF);
		rd(8'h0C, 32'h0, 32'hFFFFFFFF);
		rd(8'h10, 32'hF, 32'hF);
		rd(8'h14, 32'h0, 32'hFFFFFFFF);
		wr(8'h00, 32'h3); wr(8'h0C, 32'h1);
		rd(8'h04, 32'h1, 32'h1);
		ck(1);
		wr(8'h10, 32'h0); ck(0); wr(8'h10, 32'hF);
		wr(8'h0C, 32'h0); wr(8'h04, $random(seed) & 32'hFFFFFFFE);
		rd(8'h04, 32'h1, 32'h1);
		wr(8'h04, 32'h1); rd(8'h04, 32'h0, 32'h1);
		wr(8'h08, 32'h0); rd(8'h04, 32'h0, 32'h1);
		wr(8'h00, 32'h4003); tog;
		rd(8'h04, 32'h7, 32'hF);
		wr(8'h04, 32'h5); rd(8'h04, 32'h3, 32'hF);
		wr(8'h08, 32'hFFFF); wr(8'h04, 32'h7);
		rd(8'h04, 32'h2, 32'hF);
		wr(8'h08, 32'h1); wr(8'h0C, 32'h1); wr(8'h04, 32'h1);
		rd(8'h04, 32'h0, 32'h1);
		wr(8'h08, 32'hFFFF); wr(8'h0C, 32'h0);
		ck(0); tog;
		rd(8'h04, 32'h4, 32'hF);
		ck(1);
		wr(8'h04, 32'h4); ck(0);
		half <= 16'h0700 + ($random(seed) & 16'h03FF);
		wr(8'h00, 32'h8402); spin;
		rd(8'h04, 32'h8, 32'h8);
		ck(1);
		wr(8'h04, 32'h8); rd(8'h04, 32'h0, 32'h8);
		ck(0); spin;
		wr(8'h00, 32'h8002); rd(8'h04, 32'h0, 32'h8);
		ck(0);
		conclude;
	end
endmodule // testbench
